// ---- verilog/cdsc_pkg.sv ----
// constants and types for the clock divider and sleep control block
package cdsc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int              ADDR_W        = 8;
	localparam logic [7:0]      OFS_CLK_DIV   = 8'h00;
	localparam logic [7:0]      OFS_CORE_CTRL = 8'h04;
	localparam logic [7:0]      OFS_STATUS    = 8'h08;
	localparam logic [1:0]      RESP_OKAY     = 2'h0;
	localparam logic [1:0]      RESP_DECERR   = 2'h3;

	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int              UNLOCK_BIT    = 7;
	localparam int              DIV_SEL_MSB   = 3;
	localparam int              SLEEP_ARM_BIT = 5;
	localparam int              SLEEP_SEL_MSB = 4;
	localparam int              SLEEP_SEL_LSB = 3;
	localparam int              STAT_CODE_LSB = 8;
	localparam logic [7:0]      UNLOCK_PATTERN = 8'h80;

	// ----------------------------------------------------------------
	// divider codes
	// ----------------------------------------------------------------
	localparam logic [3:0]      DIV_CODE_ONE   = 4'h0;
	localparam logic [3:0]      DIV_CODE_EIGHT = 4'h3;
	localparam logic [3:0]      DIV_CODE_MAX   = 4'h8;

	// ----------------------------------------------------------------
	// timing, in master clock cycles
	// ----------------------------------------------------------------
	localparam logic [2:0]      UNLOCK_WINDOW  = 3'h4;
	localparam logic [2:0]      HOLD_CYCLES    = 3'h4;
	localparam logic [2:0]      STARTUP_CYCLES = 3'h6;
	localparam logic [2:0]      COUNT_LAST     = 3'h1;

	// ----------------------------------------------------------------
	// clock gate sets {cpu, flash, io, adc, osc}
	// ----------------------------------------------------------------
	localparam int              GATE_CPU   = 4;
	localparam int              GATE_FLASH = 3;
	localparam int              GATE_IO    = 2;
	localparam int              GATE_ADC   = 1;
	localparam int              GATE_OSC   = 0;
	localparam logic [4:0]      GATE_RUN   = 5'h1F;
	localparam logic [4:0]      GATE_IDLE  = 5'h07;
	localparam logic [4:0]      GATE_ADCNR = 5'h03;
	localparam logic [4:0]      GATE_PDOWN = 5'h00;
	localparam logic [4:0]      GATE_STBY  = 5'h01;

	typedef enum logic [1:0] {
		CDSC_MODE_IDLE,
		CDSC_MODE_ADCNR,
		CDSC_MODE_PDOWN,
		CDSC_MODE_STBY
	} cdsc_mode_t;

	typedef enum logic [1:0] {
		CDSC_ACTIVE,
		CDSC_ASLEEP,
		CDSC_START,
		CDSC_HOLD
	} cdsc_state_t;

endpackage : cdsc_pkg

// ---- verilog/cdsc_sync.sv ----
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
module cdsc_sync #(
	parameter int W = 2
) (
	// clock and freeze
	input  wire logic         aclk,
	input  wire logic         ce,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} cdsc_sync_state_t;

	cdsc_sync_state_t s;
	cdsc_sync_state_t next_s;

	always_comb begin
		next_s.meta = d;
		next_s.q    = s.meta;
	end

	// no reset: straps must be visible while reset is held
	always_ff @(posedge aclk) begin
		if (ce) begin
			s <= next_s;
		end
	end

	assign q = s.q;

endmodule : cdsc_sync

// ---- verilog/cdsc_div.sv ----
// power-of-two system clock divider with boundary-aligned switching
`timescale 1ns/10ps
module cdsc_div
	import cdsc_pkg::*;
(
	// clock, reset, freeze
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	// setting and result
	input  wire logic [3:0] code,
	output logic            tick,
	output logic      [3:0] active_code
);

	typedef struct packed {
		logic [7:0] cnt;
		logic [3:0] code_act;
		logic       tick;
	} cdsc_div_state_t;

	cdsc_div_state_t s;
	cdsc_div_state_t next_s;
	logic [7:0]      limit;
	logic [3:0]      code_lim;

	always_comb begin
		code_lim = (code > DIV_CODE_MAX) ? DIV_CODE_MAX : code;
		limit    = 8'((9'h001 << s.code_act) - 9'h001);
		next_s   = s;
		next_s.tick = 1'b0;
		if (s.cnt == limit) begin
			// new ratio only at a period boundary: no short period
			next_s.cnt      = 8'h00;
			next_s.code_act = code_lim;
			next_s.tick     = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign tick        = s.tick;
	assign active_code = s.code_act;

	property p_no_short_period;
		@(posedge aclk) disable iff (!aresetn || !ce)
		(s.tick && s.code_act != DIV_CODE_ONE) |=> !s.tick;
	endproperty
	a_no_short_period: assert property (p_no_short_period)
		else $error("divided clock period shorter than selected");

	property p_code_range;
		@(posedge aclk) disable iff (!aresetn)
		s.code_act <= DIV_CODE_MAX;
	endproperty
	a_code_range: assert property (p_code_range)
		else $error("active divider code above 256 ratio");

endmodule : cdsc_div

// ---- verilog/cdsc_top.sv ----
// clock divider and sleep control with AXI4-Lite registers
// Notes on behaviour
// - unlock bit sets only on a write of exactly unlock-one, all others zero
// - unlock clears four cycles after set, or at once on a select write
// - repeated unlock writes neither restart the countdown nor clear it
// - divider register bits six to four always read zero
// - select code n divides by two to the n, up to 256; above reserved
// - reset loads select 0000, or 0011 when the divide-by-eight fuse is set
// - any select code is accepted later whatever the fuse says
// - divided clock paces the core and every synchronous peripheral together
// - sleep entered only by sleep instruction while sleep arm is one
// - two-bit sleep select picks idle, noise reduction, power-down or standby
// - on wake the core is held four cycles beyond start-up, then resumes
// - sleep entry and exit leave register file and SRAM untouched
// - idle stops only core and flash clocks
// - idle wakes on any enabled interrupt
// - entering idle with converter enabled starts a conversion
// - noise reduction and power-down gate clocks and wake sources as listed
// - in those modes external irq0 wakes only when level-sensitive
// - select 10 is power-down; 11 with crystal is standby, six-cycle wake
// - sleep arm is read-write and resets to zero
// - divider changes are glitch-free with no short period
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module cdsc_top
	import cdsc_pkg::*;
(
	// clock, reset, freeze
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// fuse pins
	input  wire logic              divide_by_eight_fuse,
	input  wire logic              crystal_selected,
	// core and wake sources
	input  wire logic              sleep_instr,
	input  wire logic              adc_enabled,
	input  wire logic              ext_irq0_req,
	input  wire logic              ext_irq0_level,
	input  wire logic              pin_change_irq,
	input  wire logic              store_ready_irq,
	input  wire logic              adc_done_irq,
	input  wire logic              other_io_irq,
	input  wire logic              watchdog_irq,
	// clock enables and core control
	output logic                   sys_clk_en,
	output logic                   cpu_clk_en,
	output logic                   flash_clk_en,
	output logic                   io_clk_en,
	output logic                   adc_clk_en,
	output logic                   osc_en,
	output logic                   core_hold,
	output logic                   adc_start
);

	typedef struct packed {
		logic [3:0]        div_sel;
		logic              unlock;
		logic [2:0]        unl_cnt;
		logic              sleep_arm;
		logic [1:0]        sleep_sel;
		cdsc_state_t       state;
		cdsc_mode_t        mode;
		logic [2:0]        cnt;
		logic [4:0]        gate;
		logic              hold;
		logic              adc_start;
		logic              awready;
		logic              wready;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] waddr;
		logic [7:0]        wbyte;
		logic              wlane;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} cdsc_top_state_t;

	cdsc_top_state_t s;
	cdsc_top_state_t next_s;
	cdsc_top_state_t rst_s;
	logic            fuse_s;
	logic            xtal_s;
	logic [3:0]      div_act;
	logic            wr_fire;
	logic            wake_base;
	logic            wake;
	cdsc_mode_t      entry_mode;

	// ----------------------------------------------------------------
	// fuse synchroniser and divider
	// ----------------------------------------------------------------
	cdsc_sync #(.W(2)) u_sync (
		.aclk (aclk),
		.ce   (ce),
		.d    ({divide_by_eight_fuse, crystal_selected}),
		.q    ({fuse_s, xtal_s})
	);

	cdsc_div u_div (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.ce          (ce),
		.code        (s.div_sel),
		.tick        (sys_clk_en),
		.active_code (div_act)
	);

	// ----------------------------------------------------------------
	// wake sources and mode decode
	// ----------------------------------------------------------------
	always_comb begin
		wake_base = watchdog_irq | pin_change_irq | (ext_irq0_req & ext_irq0_level);
		unique case (s.mode)
			CDSC_MODE_IDLE:  wake = wake_base | ext_irq0_req | store_ready_irq
			                      | adc_done_irq | other_io_irq;
			CDSC_MODE_ADCNR: wake = wake_base | store_ready_irq | adc_done_irq;
			CDSC_MODE_PDOWN: wake = wake_base;
			CDSC_MODE_STBY:  wake = wake_base;
		endcase
		entry_mode = cdsc_mode_t'(s.sleep_sel);
		if (entry_mode == CDSC_MODE_STBY && !xtal_s) begin
			entry_mode = CDSC_MODE_PDOWN;
		end
	end

	assign wr_fire = s.aw_got && s.w_got && !s.bvalid;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		rst_s         = '0;
		rst_s.div_sel = fuse_s ? DIV_CODE_EIGHT : DIV_CODE_ONE;
		rst_s.state   = CDSC_ACTIVE;
		rst_s.mode    = CDSC_MODE_IDLE;
		rst_s.gate    = GATE_RUN;
		rst_s.awready = 1'b1;
		rst_s.wready  = 1'b1;
		rst_s.arready = 1'b1;

		next_s           = s;
		next_s.adc_start = 1'b0;

		// unlock window countdown, never reloaded while pending
		if (s.unlock) begin
			next_s.unl_cnt = s.unl_cnt - 3'h1;
			if (s.unl_cnt == COUNT_LAST) begin
				next_s.unlock = 1'b0;
			end
		end

		// write channel
		if (awvalid && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.waddr  = awaddr;
		end
		if (wvalid && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wbyte = wdata[7:0];
			next_s.wlane = wstrb[0];
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = RESP_OKAY;
			if (s.waddr == OFS_CLK_DIV) begin
				if (s.wlane && s.wbyte == UNLOCK_PATTERN) begin
					if (!s.unlock) begin
						next_s.unlock  = 1'b1;
						next_s.unl_cnt = UNLOCK_WINDOW;
					end
				end else if (s.wlane && s.unlock && !s.wbyte[UNLOCK_BIT]) begin
					next_s.div_sel = s.wbyte[DIV_SEL_MSB:0];
					next_s.unlock  = 1'b0;
				end
			end else if (s.waddr == OFS_CORE_CTRL) begin
				if (s.wlane) begin
					next_s.sleep_arm = s.wbyte[SLEEP_ARM_BIT];
					next_s.sleep_sel = s.wbyte[SLEEP_SEL_MSB:SLEEP_SEL_LSB];
				end
			end else if (s.waddr != OFS_STATUS) begin
				next_s.bresp = RESP_DECERR;
			end
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready  = !next_s.w_got && !next_s.bvalid;

		// read channel
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			if (araddr == OFS_CLK_DIV) begin
				next_s.rdata = (32'(s.unlock) << UNLOCK_BIT) | 32'(s.div_sel);
			end else if (araddr == OFS_CORE_CTRL) begin
				next_s.rdata = (32'(s.sleep_arm) << SLEEP_ARM_BIT)
				             | (32'(s.sleep_sel) << SLEEP_SEL_LSB);
			end else if (araddr == OFS_STATUS) begin
				next_s.rdata = (32'(div_act) << STAT_CODE_LSB) | 32'(s.state);
			end else begin
				next_s.rdata = 32'h00000000;
				next_s.rresp = RESP_DECERR;
			end
		end
		next_s.arready = !next_s.rvalid;

		// sleep sequencer; only clocks are gated, storage keeps its contents
		unique case (s.state)
			CDSC_ACTIVE: begin
				if (sleep_instr && s.sleep_arm) begin
					next_s.state = CDSC_ASLEEP;
					next_s.mode  = entry_mode;
					unique case (entry_mode)
						CDSC_MODE_IDLE:  next_s.gate = GATE_IDLE;
						CDSC_MODE_ADCNR: next_s.gate = GATE_ADCNR;
						CDSC_MODE_PDOWN: next_s.gate = GATE_PDOWN;
						CDSC_MODE_STBY:  next_s.gate = GATE_STBY;
					endcase
					next_s.adc_start = adc_enabled && (entry_mode == CDSC_MODE_IDLE
					                   || entry_mode == CDSC_MODE_ADCNR);
				end
			end
			CDSC_ASLEEP: begin
				if (wake) begin
					if (s.mode == CDSC_MODE_PDOWN || s.mode == CDSC_MODE_STBY) begin
						next_s.state = CDSC_START;
						next_s.cnt   = STARTUP_CYCLES;
						next_s.gate  = s.gate | GATE_STBY;
					end else begin
						next_s.state = CDSC_HOLD;
						next_s.cnt   = HOLD_CYCLES;
						next_s.gate  = GATE_RUN;
						next_s.hold  = 1'b1;
					end
				end
			end
			CDSC_START: begin
				next_s.cnt = s.cnt - 3'h1;
				if (s.cnt == COUNT_LAST) begin
					next_s.state = CDSC_HOLD;
					next_s.cnt   = HOLD_CYCLES;
					next_s.gate  = GATE_RUN;
					next_s.hold  = 1'b1;
				end
			end
			CDSC_HOLD: begin
				next_s.cnt = s.cnt - 3'h1;
				if (s.cnt == COUNT_LAST) begin
					next_s.state = CDSC_ACTIVE;
					next_s.hold  = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= rst_s;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign awready      = s.awready;
	assign wready       = s.wready;
	assign bvalid       = s.bvalid;
	assign bresp        = s.bresp;
	assign arready      = s.arready;
	assign rvalid       = s.rvalid;
	assign rdata        = s.rdata;
	assign rresp        = s.rresp;
	assign cpu_clk_en   = s.gate[GATE_CPU];
	assign flash_clk_en = s.gate[GATE_FLASH];
	assign io_clk_en    = s.gate[GATE_IO];
	assign adc_clk_en   = s.gate[GATE_ADC];
	assign osc_en       = s.gate[GATE_OSC];
	assign core_hold    = s.hold;
	assign adc_start    = s.adc_start;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_unlock_cause;
		@(posedge aclk) disable iff (!aresetn || !ce)
		$rose(s.unlock) |-> $past(wr_fire && s.waddr == OFS_CLK_DIV
		                          && s.wlane && s.wbyte == UNLOCK_PATTERN);
	endproperty
	a_unlock_cause: assert property (p_unlock_cause)
		else $error("unlock set without exact unlock write");

	property p_unlock_expire;
		@(posedge aclk) disable iff (!aresetn || !ce)
		$rose(s.unlock) |-> ##[1:4] !s.unlock;
	endproperty
	a_unlock_expire: assert property (p_unlock_expire)
		else $error("unlock outlived four cycles");

	property p_unlock_no_restart;
		@(posedge aclk) disable iff (!aresetn || !ce)
		(s.unlock && $past(s.unlock) && $past(ce)) |-> s.unl_cnt == $past(s.unl_cnt) - 3'h1;
	endproperty
	a_unlock_no_restart: assert property (p_unlock_no_restart)
		else $error("unlock countdown restarted");

	property p_reserved_zero;
		@(posedge aclk) disable iff (!aresetn || !ce)
		(arvalid && arready && araddr == OFS_CLK_DIV)
		|=> rvalid && rdata[6:4] == 3'h0 && rdata[UNLOCK_BIT] == $past(s.unlock);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("divider register read wrong");

	property p_reset_code;
		@(posedge aclk) $rose(aresetn)
		|-> s.div_sel == (fuse_s ? DIV_CODE_EIGHT : DIV_CODE_ONE);
	endproperty
	a_reset_code: assert property (p_reset_code)
		else $error("divider reset value ignores fuse");

	property p_sleep_entry;
		@(posedge aclk) disable iff (!aresetn || !ce)
		($past(s.state) == CDSC_ACTIVE && s.state == CDSC_ASLEEP)
		|-> $past(sleep_instr && s.sleep_arm);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep entered without arm and instruction");

	sequence seq_hold_release;
		(core_hold && cpu_clk_en)[*4] ##1 (!core_hold && s.state == CDSC_ACTIVE);
	endsequence

	sequence seq_startup;
		(s.state == CDSC_START && osc_en && !core_hold)[*6];
	endsequence

	property p_wake_fast;
		@(posedge aclk) disable iff (!aresetn || !ce)
		(s.state == CDSC_ASLEEP && wake && s.mode inside {CDSC_MODE_IDLE, CDSC_MODE_ADCNR})
		|=> seq_hold_release;
	endproperty
	a_wake_fast: assert property (p_wake_fast)
		else $error("wake hold not four cycles");

	property p_wake_slow;
		@(posedge aclk) disable iff (!aresetn || !ce)
		(s.state == CDSC_ASLEEP && wake && s.mode inside {CDSC_MODE_PDOWN, CDSC_MODE_STBY})
		|=> seq_startup ##1 seq_hold_release;
	endproperty
	a_wake_slow: assert property (p_wake_slow)
		else $error("start-up plus hold sequence wrong");

	property p_idle_gates;
		@(posedge aclk) disable iff (!aresetn || !ce)
		(s.state == CDSC_ASLEEP && s.mode == CDSC_MODE_IDLE)
		|-> !cpu_clk_en && !flash_clk_en && io_clk_en && adc_clk_en && osc_en;
	endproperty
	a_idle_gates: assert property (p_idle_gates)
		else $error("idle clock gating wrong");

	property p_deep_gates;
		@(posedge aclk) disable iff (!aresetn || !ce)
		(s.state == CDSC_ASLEEP && s.mode != CDSC_MODE_IDLE)
		|-> !io_clk_en && !cpu_clk_en && adc_clk_en == (s.mode == CDSC_MODE_ADCNR)
		    && osc_en == (s.mode != CDSC_MODE_PDOWN);
	endproperty
	a_deep_gates: assert property (p_deep_gates)
		else $error("deep sleep clock gating wrong");

	property p_edge_no_wake;
		@(posedge aclk) disable iff (!aresetn || !ce)
		(s.state == CDSC_ASLEEP && s.mode == CDSC_MODE_PDOWN && !wake_base)
		|=> s.state == CDSC_ASLEEP;
	endproperty
	a_edge_no_wake: assert property (p_edge_no_wake)
		else $error("power-down woke on edge interrupt");

	property p_adc_start;
		@(posedge aclk) disable iff (!aresetn || !ce)
		($past(s.state) == CDSC_ACTIVE && s.state == CDSC_ASLEEP)
		|-> adc_start == ($past(adc_enabled) && s.mode != CDSC_MODE_PDOWN
		                  && s.mode != CDSC_MODE_STBY);
	endproperty
	a_adc_start: assert property (p_adc_start)
		else $error("conversion start on sleep entry wrong");

endmodule : cdsc_top

// ---- bench/cdsc_tb_top.sv ----
// self-checking bench for the clock divider and sleep control block
`timescale 1ns/10ps
module cdsc_tb_top import cdsc_pkg::*; ;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic              aclk = 1'h0;
	logic              aresetn = 1'h0;
	logic              ce = 1'h1;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [2:0]        awprot = '0, arprot = '0;
	logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic              rready = 1'h0, sleep_instr = 1'h0, adc_enabled = 1'h1;
	logic [31:0]       wdata = '0, rdata;
	logic [3:0]        wstrb = 4'hF;
	logic              divide_by_eight_fuse = 1'h1, crystal_selected = 1'h1;
	logic              ext_irq0_req = 1'h0, ext_irq0_level = 1'h0, pin_change_irq = 1'h0;
	logic              store_ready_irq = 1'h0, adc_done_irq = 1'h0, other_io_irq = 1'h0;
	logic              watchdog_irq = 1'h0;
	logic              awready, wready, bvalid, arready, rvalid, sys_clk_en, cpu_clk_en;
	logic              flash_clk_en, io_clk_en, adc_clk_en, osc_en, core_hold, adc_start;
	logic [1:0]        bresp, rresp;
	int                errors = 0, cmp_count = 0, cyc = 0, n_hold = 0, n_start = 0, h, s;

	cdsc_top i_dut (.*);

	always #12.5 aclk = ~aclk;

	// cycle ceiling and pulse tallies
	always @(posedge aclk) begin
		cyc++;
		if (core_hold === 1'h1) n_hold++;
		if (adc_start === 1'h1) n_start++;
		if (cyc == 6000) begin
			errors++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// entered right after a rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		fork
			begin
				do @(posedge aclk); while (awready !== 1'h1);
				awvalid <= 1'h0;
			end
			begin
				do @(posedge aclk); while (wready !== 1'h1);
				wvalid <= 1'h0;
			end
		join
		do @(posedge aclk); while (bvalid !== 1'h1);
		chk("bresp", {30'h0, (a inside {OFS_CLK_DIV, OFS_CORE_CTRL, OFS_STATUS}) ? RESP_OKAY
		             : RESP_DECERR}, {30'h0, bresp});
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, r}, {30'h0, rresp});
	endtask : rchk

	// spacing of divided pulses, after the new code is adopted
	task automatic per(input int e);
		int n;
		repeat (3) begin
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (sys_clk_en !== 1'h1 && n < 600);
		end
		chk("period", e, n);
	endtask : per

	task automatic slp();
		sleep_instr <= 1'h1;
		@(posedge aclk);
		sleep_instr <= 1'h0;
		repeat (3) @(posedge aclk);
	endtask : slp

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk(OFS_CLK_DIV, 32'h03, RESP_OKAY);
		rchk(OFS_CORE_CTRL, 32'h00, RESP_OKAY);
		wr(8'hFC, 8'hFF);
		rchk(8'hFC, 32'h00, RESP_DECERR);
		$display("test reset done");
	endtask : t_reset

	task automatic t_unlock();
		wr(OFS_CLK_DIV, 8'h80);
		rchk(OFS_CLK_DIV, 32'h83, RESP_OKAY);
		repeat (4) @(posedge aclk);
		wr(OFS_CLK_DIV, 8'h01);
		rchk(OFS_CLK_DIV, 32'h03, RESP_OKAY);
		wr(OFS_CLK_DIV, 8'h81);
		wr(OFS_CLK_DIV, 8'h01);
		rchk(OFS_CLK_DIV, 32'h03, RESP_OKAY);
		wr(OFS_CLK_DIV, 8'h80);
		wr(OFS_CLK_DIV, 8'h80);
		wr(OFS_CLK_DIV, 8'h01);
		rchk(OFS_CLK_DIV, 32'h03, RESP_OKAY);
		wr(OFS_CLK_DIV, 8'h80);
		wr(OFS_CLK_DIV, 8'h72);
		rchk(OFS_CLK_DIV, 32'h02, RESP_OKAY);
		per(4);
		wr(OFS_CLK_DIV, 8'h80);
		wr(OFS_CLK_DIV, 8'h08);
		per(256);
		$display("test unlock done");
	endtask : t_unlock

	task automatic t_idle();
		slp();
		chk("cpu_unarmed", 32'h1, {31'h0, cpu_clk_en});
		wr(OFS_CORE_CTRL, 8'h20);
		s = n_start;
		slp();
		chk("cpu_idle", 32'h0, {31'h0, cpu_clk_en});
		chk("io_idle", 32'h1, {31'h0, io_clk_en});
		chk("flash_idle", 32'h0, {31'h0, flash_clk_en});
		chk("adc_start", s + 1, n_start);
		h = n_hold;
		other_io_irq <= 1'h1;
		repeat (12) @(posedge aclk);
		other_io_irq <= 1'h0;
		chk("hold_idle", 4, n_hold - h);
		chk("cpu_woke", 32'h1, {31'h0, cpu_clk_en});
		$display("test idle done");
	endtask : t_idle

	task automatic t_pdown();
		crystal_selected <= 1'h0;
		wr(OFS_CORE_CTRL, 8'h38);
		s = n_start;
		slp();
		chk("osc_pd", 32'h0, {31'h0, osc_en});
		chk("adc_pd", 32'h0, {31'h0, adc_clk_en});
		chk("no_start", s, n_start);
		h = n_hold;
		ext_irq0_req <= 1'h1;
		repeat (10) @(posedge aclk);
		chk("edge_irq", 32'h0, {31'h0, osc_en});
		ext_irq0_level <= 1'h1;
		repeat (20) @(posedge aclk);
		ext_irq0_req <= 1'h0;
		chk("osc_woke", 32'h1, {31'h0, osc_en});
		chk("hold_pd", 4, n_hold - h);
		$display("test power-down done");
	endtask : t_pdown

	task automatic t_adcnr();
		wr(OFS_CORE_CTRL, 8'h28);
		s = n_start;
		slp();
		chk("adc_nr", 32'h1, {31'h0, adc_clk_en});
		chk("io_nr", 32'h0, {31'h0, io_clk_en});
		chk("start_nr", s + 1, n_start);
		h = n_hold;
		other_io_irq <= 1'h1;
		repeat (5) @(posedge aclk);
		chk("io_no_wake", 32'h0, {31'h0, cpu_clk_en});
		other_io_irq <= 1'h0;
		adc_done_irq <= 1'h1;
		repeat (8) @(posedge aclk);
		adc_done_irq <= 1'h0;
		chk("hold_nr", 4, n_hold - h);
		chk("cpu_nr", 32'h1, {31'h0, cpu_clk_en});
		$display("test noise reduction done");
	endtask : t_adcnr

	task automatic t_stby();
		int n;
		crystal_selected <= 1'h1;
		wr(OFS_CORE_CTRL, 8'h38);
		slp();
		chk("osc_sb", 32'h1, {31'h0, osc_en});
		chk("adc_sb", 32'h0, {31'h0, adc_clk_en});
		h = n_hold;
		watchdog_irq <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (core_hold !== 1'h1 && n < 50);
		chk("wake_sb", 8, n);
		repeat (8) @(posedge aclk);
		watchdog_irq <= 1'h0;
		chk("hold_sb", 4, n_hold - h);
		chk("cpu_sb", 32'h1, {31'h0, cpu_clk_en});
		$display("test standby done");
	endtask : t_stby

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset();
		t_unlock();
		t_idle();
		t_pdown();
		t_adcnr();
		t_stby();
		end_of_test();
	end
endmodule : cdsc_tb_top
